// ---- besirq_pkg.sv ----
// Purpose: Shared constants and types for the board error status and interrupt block.
// Assumes: 32-bit register words, byte addresses on a 16-bit offset bus.
// Notes:   Every register offset, status field position and vector and mask reset value used by the logic lives here.
`default_nettype none
package besirq_pkg;
	localparam int          ADDR_W       = 16;
	localparam int          DATA_W       = 32;
	localparam int          VEC_W        = 8;
	localparam int          CHANS        = 4;
	localparam int          WORD_LSB     = 2;
	localparam logic [15:0] OFF_VECTOR   = 16'h0020;
	localparam logic [15:0] OFF_STATUS   = 16'h0028;
	localparam logic [15:0] OFF_REVISION = 16'h0038;
	localparam logic [15:0] OFF_MASK     = 16'h00a4;
	localparam int          AC_LSB       = 28;
	localparam int          DC_LSB       = 24;
	localparam int          SQL_LSB      = 20;
	localparam int          LOL_LSB      = 16;
	localparam int          RSVD_BIT     = 15;
	localparam int          BPL_BIT      = 14;
	localparam int          RLL_BIT      = 13;
	localparam int          REF_BIT      = 12;
	localparam int          CMP_LSB      = 8;
	localparam int          OVF_LSB      = 4;
	localparam int          DNV_LSB      = 0;
	localparam logic [31:0] FLAG_IMPL    = 32'hffff7fff;
	localparam logic [31:0] ZERO_WORD    = 32'h00000000;
	localparam logic [7:0]  VECTOR_RST   = 8'h00;
	localparam logic [31:0] MASK_RST     = 32'h00000000;

	typedef struct packed {
		logic [31:0] rdata;
		logic        rvalid;
		logic [7:0]  vector;
		logic [31:0] mask;
		logic        irq;
		logic [7:0]  iack_vec;
		logic        iack_ack;
		logic        iack_pass;
	} besirq_main_type;
endpackage
`default_nettype wire

// ---- besirq_sticky.sv ----
// Purpose: Bank of sticky flags set by events and cleared by writing one.
// Assumes: Set and clear vectors are synchronous to clk_i.
// Notes:   A set arriving in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module besirq_sticky
	import besirq_pkg::*;
#(
	parameter int W = 32
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] flags_o
);
	typedef struct packed {
		logic [W-1:0] flags;
	} besirq_flag_type;

	besirq_flag_type st_ff;
	besirq_flag_type nxt_st;

	always_comb
	begin
		nxt_st       = st_ff;
		nxt_st.flags = (st_ff.flags & ~clr_i) | set_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign flags_o = st_ff.flags;
endmodule
`default_nettype wire

// ---- besirq_event_map.sv ----
// Purpose: Gathers raw fault inputs into one 32-bit event word in status layout.
// Assumes: Channel n feeds axis n; all inputs are one-cycle or level events.
// Notes:   Squelch implies loss of lock, and loss of lock implies invalid data.
`timescale 1ns/1ps
`default_nettype none
module besirq_event_map
	import besirq_pkg::*;
(
	input  wire logic [3:0]  ac_high_i,
	input  wire logic [3:0]  dc_high_i,
	input  wire logic [3:0]  squelch_i,
	input  wire logic [3:0]  chan_lol_i,
	input  wire logic        backplane_lol_i,
	input  wire logic        ext_clk_sel_i,
	input  wire logic        ref_lol_i,
	input  wire logic        ref_err_i,
	input  wire logic [3:0]  pos_cmp_i,
	input  wire logic [3:0]  vel_cmp_i,
	input  wire logic [3:0]  pos_ovf_i,
	input  wire logic [3:0]  data_bad_i,
	output logic      [31:0] events_o
);
	logic [3:0] lol_ev;

	always_comb
	begin
		lol_ev                              = chan_lol_i | squelch_i;
		events_o                            = ZERO_WORD;
		events_o[AC_LSB +: CHANS]           = ac_high_i;
		events_o[DC_LSB +: CHANS]           = dc_high_i;
		events_o[SQL_LSB +: CHANS]          = squelch_i;
		events_o[LOL_LSB +: CHANS]          = lol_ev;
		events_o[BPL_BIT]                   = backplane_lol_i & ext_clk_sel_i;
		events_o[RLL_BIT]                   = ref_lol_i;
		events_o[REF_BIT]                   = ref_err_i;
		events_o[CMP_LSB +: CHANS]          = pos_cmp_i | vel_cmp_i;
		events_o[OVF_LSB +: CHANS]          = pos_ovf_i;
		events_o[DNV_LSB +: CHANS]          = data_bad_i | lol_ev;
	end
endmodule
`default_nettype wire

// ---- besirq_top.sv ----
// Purpose: Board error status, interrupt mask, vector and revision registers with IRQ.
// Assumes: Register port and acknowledge strobes are synchronous one-cycle pulses.
// Notes:   Read data and acknowledge answers appear one cycle after the strobe.
// Notes on behaviour
// - Status bits 31..28 latch AC clipping on channels 4..1 until cleared.
// - Status bits 27..24 latch DC power over limit on channels 4..1.
// - Bits 23..20 latch below-squelch; squelch also latches channel loss of lock.
// - Bits 19..16 latch loss of lock, which also latches data-invalid.
// - Bit 14 latches backplane clock loss only when external clock selected.
// - Bit 13 latches reference lost lock, bit 12 any reference error.
// - Bits 11..8 latch position OR velocity comparator hit per axis.
// - Bits 7..4 latch position overflow per axis.
// - Bits 3..0 latch invalid data per axis; zero means valid.
// - Flags stay set; only writing one to a bit clears it.
// - Revision bits 31..16 give hardware letter and two minor nibbles.
// - Revision bits 15..0 give firmware letter and two minor nibbles.
// - Own interrupt acknowledge returns the 8-bit vector.
// - Vector is readable by normal reads; host ignores upper bits.
// - Vector bits 31..8 read zero, ignore writes; vector resets to zero.
// - No interrupt request unless the global IRQ enable is set.
// - Mask bit n enables status bit n onto the interrupt.
// - Mask bits read/write, reset zero; bit 15 reserved.
// - Undefined bits read zero; writes to them have no effect.
`timescale 1ns/1ps
`default_nettype none
module besirq_top
	import besirq_pkg::*;
#(
	parameter logic [7:0] HW_MAJOR  = 8'h42, // Arbitrary value.
	parameter logic [3:0] HW_MINOR1 = 4'h0,  // Arbitrary value.
	parameter logic [3:0] HW_MINOR2 = 4'h3,  // Arbitrary value.
	parameter logic [7:0] FW_MAJOR  = 8'h43, // Arbitrary value.
	parameter logic [3:0] FW_MINOR1 = 4'h1,  // Arbitrary value.
	parameter logic [3:0] FW_MINOR2 = 4'h2   // Arbitrary value.
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [DATA_W-1:0] reg_wdata_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	output logic                   reg_rvalid_o,
	input  wire logic              irq_enable_i,
	input  wire logic              iack_i,
	output logic      [VEC_W-1:0]  iack_vector_o,
	output logic                   iack_ack_o,
	output logic                   iack_pass_o,
	output logic                   irq_o,
	input  wire logic [3:0]        ac_high_i,
	input  wire logic [3:0]        dc_high_i,
	input  wire logic [3:0]        squelch_i,
	input  wire logic [3:0]        chan_lol_i,
	input  wire logic              backplane_lol_i,
	input  wire logic              ext_clk_sel_i,
	input  wire logic              ref_lol_i,
	input  wire logic              ref_err_i,
	input  wire logic [3:0]        pos_cmp_i,
	input  wire logic [3:0]        vel_cmp_i,
	input  wire logic [3:0]        pos_ovf_i,
	input  wire logic [3:0]        data_bad_i
);
	////////////////////////////////////////////////////////////////////////////////////////
	besirq_main_type st_ff;
	besirq_main_type nxt_st;
	logic [31:0]     events;
	logic [31:0]     status;
	logic [31:0]     status_clr;
	logic [31:0]     revision;
	logic [13:0]     word_addr;
	logic            hit_vector;
	logic            hit_status;
	logic            hit_rev;
	logic            hit_mask;
	logic            pending;

	besirq_event_map u_event_map (
		.ac_high_i       (ac_high_i),
		.dc_high_i       (dc_high_i),
		.squelch_i       (squelch_i),
		.chan_lol_i      (chan_lol_i),
		.backplane_lol_i (backplane_lol_i),
		.ext_clk_sel_i   (ext_clk_sel_i),
		.ref_lol_i       (ref_lol_i),
		.ref_err_i       (ref_err_i),
		.pos_cmp_i       (pos_cmp_i),
		.vel_cmp_i       (vel_cmp_i),
		.pos_ovf_i       (pos_ovf_i),
		.data_bad_i      (data_bad_i),
		.events_o        (events)
	);

	besirq_sticky #(
		.W (DATA_W)
	) u_status (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (events),
		.clr_i   (status_clr),
		.flags_o (status)
	);

	////////////////////////////////////////////////////////////////////////////////////////
	// The byte lane offset is dropped so a half-word access lands on the same register.
	assign word_addr  = reg_addr_i[ADDR_W-1:WORD_LSB];
	assign hit_vector = (word_addr == OFF_VECTOR[ADDR_W-1:WORD_LSB]);
	assign hit_status = (word_addr == OFF_STATUS[ADDR_W-1:WORD_LSB]);
	assign hit_rev    = (word_addr == OFF_REVISION[ADDR_W-1:WORD_LSB]);
	assign hit_mask   = (word_addr == OFF_MASK[ADDR_W-1:WORD_LSB]);
	assign status_clr = (reg_wr_i && hit_status) ? (reg_wdata_i & FLAG_IMPL) : ZERO_WORD;
	assign revision   = {HW_MAJOR, HW_MINOR1, HW_MINOR2, FW_MAJOR, FW_MINOR1, FW_MINOR2};
	assign pending    = irq_enable_i && ((status & st_ff.mask) != ZERO_WORD);

	always_comb
	begin
		nxt_st           = st_ff;
		nxt_st.rvalid    = reg_rd_i;
		nxt_st.iack_ack  = 1'b0;
		nxt_st.iack_pass = 1'b0;
		nxt_st.irq       = pending;
		if (reg_wr_i && hit_vector)
			nxt_st.vector = reg_wdata_i[VEC_W-1:0];
		if (reg_wr_i && hit_mask)
			nxt_st.mask = reg_wdata_i & FLAG_IMPL;
		if (reg_rd_i)
		begin
			if (hit_vector)
				nxt_st.rdata = {24'h000000, st_ff.vector};
			else if (hit_status)
				nxt_st.rdata = status;
			else if (hit_rev)
				nxt_st.rdata = revision;
			else if (hit_mask)
				nxt_st.rdata = st_ff.mask;
			else
				nxt_st.rdata = ZERO_WORD;
		end
		if (iack_i)
		begin
			if (st_ff.irq)
			begin
				nxt_st.iack_vec = st_ff.vector;
				nxt_st.iack_ack = 1'b1;
			end
			else
				nxt_st.iack_pass = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_ff          <= '0;
			st_ff.vector   <= VECTOR_RST;
			st_ff.mask     <= MASK_RST;
		end
		else
			st_ff <= nxt_st;
	end

	assign reg_rdata_o   = st_ff.rdata;
	assign reg_rvalid_o  = st_ff.rvalid;
	assign iack_vector_o = st_ff.iack_vec;
	assign iack_ack_o    = st_ff.iack_ack;
	assign iack_pass_o   = st_ff.iack_pass;
	assign irq_o         = st_ff.irq;

	////////////////////////////////////////////////////////////////////////////////////////
	sequence s_iack_own;
		iack_i && irq_o;
	endsequence

	sequence s_iack_answer;
		iack_ack_o && !iack_pass_o && (iack_vector_o == $past(st_ff.vector));
	endsequence

	property p_ac_latch;
		@(posedge clk_i) disable iff (rst_i)
		ac_high_i[0] |=> status[AC_LSB];
	endproperty
	a_ac_latch: assert property (p_ac_latch) else $error("AC flag did not latch.");

	property p_dc_latch;
		@(posedge clk_i) disable iff (rst_i)
		dc_high_i[3] |=> status[DC_LSB + 3];
	endproperty
	a_dc_latch: assert property (p_dc_latch) else $error("DC flag did not latch.");

	property p_squelch_chain;
		@(posedge clk_i) disable iff (rst_i)
		squelch_i[1] |=> status[SQL_LSB + 1] && status[LOL_LSB + 1] && status[DNV_LSB + 1];
	endproperty
	a_squelch_chain: assert property (p_squelch_chain) else $error("Squelch chain missing.");

	property p_lol_invalid;
		@(posedge clk_i) disable iff (rst_i)
		chan_lol_i[2] |=> status[LOL_LSB + 2] && status[DNV_LSB + 2];
	endproperty
	a_lol_invalid: assert property (p_lol_invalid) else $error("Loss of lock kept data valid.");

	property p_bp_gate;
		@(posedge clk_i) disable iff (rst_i)
		(!status[BPL_BIT] && !ext_clk_sel_i) |=> !status[BPL_BIT];
	endproperty
	a_bp_gate: assert property (p_bp_gate) else $error("Backplane flag set on internal clock.");

	property p_cmp_or;
		@(posedge clk_i) disable iff (rst_i)
		vel_cmp_i[3] |=> status[CMP_LSB + 3];
	endproperty
	a_cmp_or: assert property (p_cmp_or) else $error("Velocity compare not latched.");

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(reg_wr_i && hit_status) |=> ((status & $past(status)) == $past(status));
	endproperty
	a_hold: assert property (p_hold) else $error("Status flag dropped without a clear.");

	property p_set_wins;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && hit_status) |=> ((status & $past(events)) == $past(events));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Clear beat a new event.");

	property p_iack;
		@(posedge clk_i) disable iff (rst_i)
		s_iack_own |=> s_iack_answer;
	endproperty
	a_iack: assert property (p_iack) else $error("Acknowledge did not return the vector.");

	property p_vec_read;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && hit_vector) |=> reg_rvalid_o && (reg_rdata_o[31:8] == 24'h000000);
	endproperty
	a_vec_read: assert property (p_vec_read) else $error("Vector upper bits not zero.");

	property p_no_enable;
		@(posedge clk_i) disable iff (rst_i)
		!irq_enable_i [*2] |-> !irq_o;
	endproperty
	a_no_enable: assert property (p_no_enable) else $error("Interrupt without global enable.");

	property p_irq_track;
		@(posedge clk_i) disable iff (rst_i)
		##1 (irq_o == $past(pending));
	endproperty
	a_irq_track: assert property (p_irq_track) else $error("Interrupt does not follow flags.");

	property p_mask_rsvd;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && hit_mask) |=> (st_ff.mask == ($past(reg_wdata_i) & FLAG_IMPL));
	endproperty
	a_mask_rsvd: assert property (p_mask_rsvd) else $error("Mask write mismatched.");

	property p_unmapped;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && !hit_vector && !hit_status && !hit_rev && !hit_mask)
			|=> (reg_rdata_o == ZERO_WORD);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");

	property p_ref_lol;
		@(posedge clk_i) disable iff (rst_i)
		ref_lol_i |=> status[RLL_BIT];
	endproperty
	a_ref_lol: assert property (p_ref_lol) else $error("Reference lost lock not latched.");

	property p_ovf_latch;
		@(posedge clk_i) disable iff (rst_i)
		pos_ovf_i[3] |=> status[OVF_LSB + 3];
	endproperty
	a_ovf_latch: assert property (p_ovf_latch) else $error("Overflow flag did not latch.");

	property p_bad_latch;
		@(posedge clk_i) disable iff (rst_i)
		data_bad_i[2] |=> status[DNV_LSB + 2];
	endproperty
	a_bad_latch: assert property (p_bad_latch) else $error("Invalid data flag did not latch.");

	property p_rev_letters;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && hit_rev)
			|=> (reg_rdata_o[31:24] >= 8'h41) && (reg_rdata_o[31:24] <= 8'h5a)
			&& (reg_rdata_o[15:8] >= 8'h41) && (reg_rdata_o[15:8] <= 8'h5a);
	endproperty
	a_rev_letters: assert property (p_rev_letters) else $error("Revision letter out of range.");

	property p_status_read;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && hit_status)
			|=> (reg_rdata_o == $past(status)) && !reg_rdata_o[RSVD_BIT];
	endproperty
	a_status_read: assert property (p_status_read) else $error("Status read mismatched.");

	property p_mask_gate;
		@(posedge clk_i) disable iff (rst_i)
		((status & st_ff.mask) == ZERO_WORD) |=> !irq_o;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("Masked flag raised an interrupt.");

	property p_iack_pass;
		@(posedge clk_i) disable iff (rst_i)
		(iack_i && !irq_o) |=> iack_pass_o && !iack_ack_o;
	endproperty
	a_iack_pass: assert property (p_iack_pass) else $error("Idle acknowledge not passed.");
endmodule
`default_nettype wire

// ---- besirq_host_model.sv ----
// Purpose: Host side model that issues register, enable and acknowledge cycles.
// Assumes: Strobes are one-cycle pulses launched just after a rising edge.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module besirq_host_model
	import besirq_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [DATA_W-1:0] rdata_i,
	input  wire logic              rvalid_i,
	input  wire logic [VEC_W-1:0]  vec_i,
	input  wire logic              ack_i,
	input  wire logic              pass_i,
	output logic      [ADDR_W-1:0] addr_o,
	output logic                   wr_o,
	output logic                   rd_o,
	output logic      [DATA_W-1:0] wdata_o,
	output logic                   en_o,
	output logic                   iack_o
);
	initial
	begin
		addr_o  = 16'h0000;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		wdata_o = 32'h00000000;
		en_o    = 1'b0;
		iack_o  = 1'b0;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
		@(posedge clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i;
		v = rvalid_i;
	endtask

	// The board only requests an interrupt once this enable is set.
	task automatic en(input logic e);
		@(posedge clk_i);
		en_o <= e;
	endtask

	task automatic ack(output logic a, output logic p, output logic [VEC_W-1:0] v);
		@(posedge clk_i);
		iack_o <= 1'b1;
		@(posedge clk_i);
		iack_o <= 1'b0;
		@(posedge clk_i);
		a = ack_i;
		p = pass_i;
		v = vec_i;
	endtask
endmodule
`default_nettype wire

// ---- tb_board_error_status_irq.sv ----
// Purpose: Self-checking bench for the board error status and interrupt block.
// Assumes: Event vectors are packed in ev in port order, bit 32 up are singles.
// Notes:   Every scenario task drives the block and judges the answers itself.
`timescale 1ns/1ps
`default_nettype none
module tb_board_error_status_irq
	import besirq_pkg::*;
;
	logic              clk_i;
	logic              rst_i;
	logic [35:0]       ev;
	logic [ADDR_W-1:0] addr;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              rvalid;
	logic              en;
	logic              iack;
	logic [VEC_W-1:0]  vec;
	logic              ack;
	logic              pass;
	logic              irq;
	int                n_errors;
	int                checks;

	besirq_top dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.irq_enable_i(en), .iack_i(iack), .iack_vector_o(vec), .iack_ack_o(ack),
		.iack_pass_o(pass), .irq_o(irq), .ac_high_i(ev[3:0]), .dc_high_i(ev[7:4]),
		.squelch_i(ev[11:8]), .chan_lol_i(ev[15:12]), .pos_cmp_i(ev[19:16]),
		.vel_cmp_i(ev[23:20]), .pos_ovf_i(ev[27:24]), .data_bad_i(ev[31:28]),
		.backplane_lol_i(ev[32]), .ext_clk_sel_i(ev[33]), .ref_lol_i(ev[34]),
		.ref_err_i(ev[35]));

	besirq_host_model hm (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .vec_i(vec),
		.ack_i(ack), .pass_i(pass), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
		.en_o(en), .iack_o(iack));

	task automatic end_of_test;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_rd(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic        v;
		hm.rd(a, d, v);
		chk({n, "_rvalid"}, 32'h00000001, {31'h0, v});
		chk(n, e, d);
	endtask

	task automatic pulse(input int b);
		@(posedge clk_i);
		ev[b] <= 1'b1;
		@(posedge clk_i);
		ev[b] <= 1'b0;
	endtask

	task automatic chk_irq(input logic e);
		repeat (3) @(posedge clk_i);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask

	task automatic t_reset;
		chk_rd("vector", OFF_VECTOR, ZERO_WORD);
		chk_rd("mask", OFF_MASK, ZERO_WORD);
		chk_rd("status", OFF_STATUS, ZERO_WORD);
		chk_rd("revision", OFF_REVISION, 32'h42034312);
	endtask

	task automatic t_regs;
		hm.wr(OFF_VECTOR, 32'hffffffa5);
		chk_rd("vector", OFF_VECTOR, 32'h000000a5);
		hm.wr(OFF_MASK, 32'hffffffff);
		chk_rd("mask", OFF_MASK, 32'hffff7fff);
		hm.wr(OFF_MASK, 32'h00000000);
		hm.wr(OFF_REVISION, 32'h00000000);
		chk_rd("revision", OFF_REVISION, 32'h42034312);
		hm.wr(16'h0030, 32'hffffffff);
		chk_rd("unmapped", 16'h0030, ZERO_WORD);
	endtask

	task automatic t_events;
		int          idx[11] = '{0, 7, 9, 14, 16, 21, 27, 30, 32, 34, 35};
		logic [31:0] ex[11] = '{32'h10000000, 32'h08000000, 32'h00220002, 32'h00040004,
			32'h00000100, 32'h00000200, 32'h00000080, 32'h00000004, 32'h00000000,
			32'h00002000, 32'h00001000};
		for (int i = 0; i <= 11; i++)
		begin
			if (i == 11)
				ev[33] <= 1'b1;
			pulse(i == 11 ? 32 : idx[i]);
			chk_rd("status_event", OFF_STATUS, i == 11 ? 32'h00004000 : ex[i]);
			hm.wr(OFF_STATUS, 32'hffffffff);
			chk_rd("status_clear", OFF_STATUS, ZERO_WORD);
		end
		ev[33] <= 1'b0;
	endtask

	task automatic t_w1c;
		pulse(28);
		pulse(24);
		hm.wr(OFF_STATUS, 32'h00000000);
		chk_rd("status_w0", OFF_STATUS, 32'h00000011);
		hm.wr(OFF_STATUS, 32'h00000001);
		chk_rd("status_w1", OFF_STATUS, 32'h00000010);
		fork
			hm.wr(OFF_STATUS, 32'h00000011);
			pulse(28);
		join
		chk_rd("status_race", OFF_STATUS + 16'h0002, 32'h00000001);
		hm.wr(OFF_STATUS, 32'hffffffff);
	endtask

	task automatic t_irq;
		logic             a;
		logic             p;
		logic [VEC_W-1:0] v;
		hm.wr(OFF_VECTOR, 32'h0000003c);
		pulse(28);
		chk_irq(1'b0);
		hm.wr(OFF_MASK, 32'h00000001);
		chk_irq(1'b0);
		hm.en(1'b1);
		chk_irq(1'b1);
		hm.ack(a, p, v);
		chk("iack", 32'h0000023c, {22'h0, a, p, v});
		hm.wr(OFF_MASK, 32'h00000002);
		chk_irq(1'b0);
		hm.wr(OFF_MASK, 32'h00000001);
		chk_irq(1'b1);
		hm.wr(OFF_STATUS, 32'h00000001);
		chk_irq(1'b0);
		hm.ack(a, p, v);
		chk("iack_pass", 32'h00000001, {30'h0, a, p});
		hm.en(1'b0);
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		end_of_test();
	end

	initial
	begin
		n_errors = 0;
		checks   = 0;
		rst_i    = 1'b1;
		ev       = 36'h000000000;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_regs();
		t_events();
		t_w1c();
		t_irq();
		end_of_test();
	end
endmodule
`default_nettype wire
